/* logic/rhi_map.svh */
// address map, register indices, bit positions and timing figures
// assumes a 32-bit apb bus with one aligned word per register
`ifndef RHI_MAP_SVH
`define RHI_MAP_SVH
// byte addresses: registers from 0, pin register, then frame buffer
`define RHI_REG_END 12'h040
`define RHI_PIN_ADDR 12'h100
`define RHI_FB_FIRST 12'h200
`define RHI_FB_LAST 12'h3fc
// transceiver register indices
`define RHI_IDX_STATE 4'h0
`define RHI_IDX_CMD 4'h1
`define RHI_IDX_RXLEN 4'h2
`define RHI_IDX_FREE 4'h3
// pin-function register bits
`define RHI_PIN_RST 0
`define RHI_PIN_TRIG 1
// state command codes and register reset value
`define RHI_CMD_OFF 8'h01
`define RHI_CMD_PLL 8'h02
`define RHI_CMD_RX 8'h03
`define RHI_CMD_AACK 8'h04
`define RHI_CMD_ARET 8'h05
`define RHI_REG_RST 8'h00
// timing
`define RHI_ACC_EDGES 2'h3
`define RHI_PCLK_NS 10
`define RHI_LOST_NS 125
`endif

/* logic/rhi_pkg.sv */
// types shared by the radio host interface
// assumes nothing beyond a systemverilog compiler
package rhi_pkg;
    // radio operating states
    typedef enum logic [3:0] {
        st_off, st_sleep, st_pll_on, st_busy_tx, st_aret_on,
        st_busy_aret, st_rx_on, st_aack_on, st_rx_hold
    } rhi_state_t;
    // register access phases
    typedef enum logic {acc_idle, acc_wait} rhi_acc_t;
endpackage

/* logic/rhi_sync.sv */
// two-flop synchroniser with rising-edge pulse
// assumes async_in may change at any time relative to pclk
`timescale 1ns/1ps
module rhi_sync (
    input wire logic pclk, // controller clock
    input wire logic presetn, // async reset, active low
    input wire logic async_in, // level from outside the domain
    output logic rise // one-cycle pulse per rising edge
);
    logic s1_q, s2_q, s3_q;

    // s1 is read by s2 only, to contain metastability
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign rise = s2_q & ~s3_q;
endmodule

/* logic/rhi_top.sv */
// radio host interface: apb registers, frame buffer, pin-function logic
// assumes an apb master on pclk and a radio clock pin that stops while trx_clk_en is low
// What this block does
// - radio clock is its own pin; silence timeout assumes a 10 ns controller clock
// - a radio register access completes within three radio clock edges
// - the bus waits while a radio register access is pending
// - with the radio clock stopped, register reads return zero
// - frame buffer holds 128 bytes, one maximum frame
// - buffer sits above registers, random byte access from either end
// - buffer accesses finish in one cycle with no waits
// - buffer changes only by reception or by a bus write
// - received length goes to its own register, not the buffer
// - link quality byte lands right after the received data
// - pin-function register works on pclk, even in sleep
// - soft reset bit resets only the radio and clears itself
// - trigger bit keeps its value, hardware never clears it
// - trigger rise starts a send in pll-on or auto-retry states
// - trigger rise in off sleeps; trigger fall in sleep wakes
// - rise in off or receive states holds new state until fall
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "rhi_map.svh"
module rhi_top #(
    parameter int ADDR_W = 12, // apb address width
    parameter int N_REGS = 16, // radio register count
    parameter int FB_DEPTH = 128 // frame buffer bytes
) (
    input wire logic pclk, // controller clock
    input wire logic presetn, // async reset, active low
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic trx_clk, // 16 mhz radio clock pin
    input wire logic power_reduction_ctrl, // 1 powers the radio down
    input wire logic rx_len_valid, // frame length received
    input wire logic [7:0] rx_len, // received length
    input wire logic rx_byte_valid, // received data byte
    input wire logic [7:0] rx_byte, // data byte
    input wire logic rx_lqi_valid, // link quality byte ready
    input wire logic [7:0] rx_lqi, // link quality value
    input wire logic tx_done, // transmitter finished a frame
    input wire logic [$clog2(FB_DEPTH)-1:0] tx_rd_idx, // tx read index
    output logic [7:0] tx_rd_byte, // buffer byte at tx_rd_idx
    output logic tx_start, // one-cycle transmit start
    output logic radio_reset, // one-cycle radio-only reset
    output logic trx_clk_en, // radio clock gate
    output rhi_pkg::rhi_state_t radio_state // current radio state
);
    import rhi_pkg::*;

    localparam int FB_AW = $clog2(FB_DEPTH);
    localparam int LOST_CYC =
        (`RHI_LOST_NS + `RHI_PCLK_NS - 1) / `RHI_PCLK_NS;

    rhi_state_t st_q, st_d, prev_q;
    rhi_acc_t acc_q;
    logic [7:0] fb_mem [FB_DEPTH];
    logic [7:0] regs_q [N_REGS];
    logic [7:0] rxlen_q, tx_rd_byte_q;
    logic [FB_AW-1:0] wr_ptr_q;
    logic [1:0] cnt_q;
    logic [4:0] lost_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, wr_ok_q, trig_q;
    logic tx_start_q, radio_reset_q, trx_clk_en_q;

    // state command decode; ignored while busy or held
    function automatic rhi_state_t cmd_state(input logic [7:0] c,
                                             input rhi_state_t s);
        cmd_state = s;
        if (s == st_off || s == st_pll_on || s == st_rx_on ||
            s == st_aack_on || s == st_aret_on) begin
            case (c)
                `RHI_CMD_OFF: cmd_state = st_off;
                `RHI_CMD_PLL: cmd_state = st_pll_on;
                `RHI_CMD_RX: cmd_state = st_rx_on;
                `RHI_CMD_AACK: cmd_state = st_aack_on;
                `RHI_CMD_ARET: cmd_state = st_aret_on;
                default: cmd_state = s;
            endcase
        end
    endfunction

    // radio clock pin enters through two flops before use
    wire trx_rise;
    rhi_sync u_trx_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(trx_clk),
        .rise(trx_rise)
    );

    // address decode; buffer bytes are one word each, first to last
    wire [ADDR_W-1:0] fb_off = paddr - ADDR_W'(`RHI_FB_FIRST);
    wire [FB_AW-1:0] fb_idx = fb_off[FB_AW+1:2];
    wire a_fb = paddr >= ADDR_W'(`RHI_FB_FIRST) &&
        paddr <= ADDR_W'(`RHI_FB_LAST);
    wire a_pin = paddr == ADDR_W'(`RHI_PIN_ADDR);
    wire a_reg = paddr < ADDR_W'(`RHI_REG_END);
    wire [3:0] reg_idx = paddr[5:2];
    wire setup = psel & ~penable;
    wire commit = psel & penable & pready_q & pwrite;

    // radio clock presence: lost after a silent stretch
    wire clk_lost = lost_q == 5'(LOST_CYC);
    wire trx_avail = ~power_reduction_ctrl & (st_q != st_sleep) &
        ~clk_lost;

    // access completion: fast paths answer at once, registers wait
    wire cnt_last = cnt_q == (`RHI_ACC_EDGES - 2'h1);
    wire done_fast = setup & ~a_reg;
    wire done_lost = setup & a_reg & ~trx_avail;
    wire done_wait = (acc_q == acc_wait) &
        ((trx_rise & cnt_last) | ~trx_avail);
    wire rsp_now = done_fast | done_lost | done_wait;

    // read data selection
    wire [7:0] reg_rd = (reg_idx == `RHI_IDX_STATE) ? {4'h0, st_q} :
        (reg_idx == `RHI_IDX_RXLEN) ? rxlen_q : regs_q[reg_idx];
    wire [7:0] pin_rd = {6'h00, trig_q, 1'b0}; // reset bit reads zero
    wire [7:0] rd_byte = a_fb ? fb_mem[fb_idx] : a_pin ? pin_rd :
        (a_reg & trx_avail) ? reg_rd : 8'h00;

    // pin register writes: soft reset pulse and held trigger bit
    wire pin_we = commit & a_pin;
    wire trx_rst = pin_we & pwdata[`RHI_PIN_RST];
    wire trig_d = pin_we ? pwdata[`RHI_PIN_TRIG] : trig_q;
    wire trig_rise = trig_d & ~trig_q;
    wire trig_fall = ~trig_d & trig_q;

    // radio register writes only after an acknowledged access
    wire reg_we = commit & a_reg & wr_ok_q;
    wire cmd_we = reg_we & (reg_idx == `RHI_IDX_CMD);
    wire fb_we = commit & a_fb;
    wire rx_ok = st_q == st_rx_on || st_q == st_aack_on ||
        st_q == st_busy_aret;
    wire rx_we = rx_ok & (rx_byte_valid | rx_lqi_valid);

    // apb answer; pready is a one-cycle pulse per access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            wr_ok_q <= 1'b0;
        end else begin
            pready_q <= rsp_now;
            pslverr_q <= rsp_now & ~(a_fb | a_pin | a_reg);
            prdata_q <= rsp_now ? {24'h00_0000, rd_byte} : 32'h0;
            wr_ok_q <= done_wait & trx_avail;
        end
    end

    // register access waits for three synchronised radio edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= acc_idle;
            cnt_q <= 2'h0;
        end else if (setup & a_reg & trx_avail) begin
            acc_q <= acc_wait;
            cnt_q <= 2'h0;
        end else if (done_wait) begin
            acc_q <= acc_idle;
        end else if (acc_q == acc_wait && trx_rise) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    // silence counter, saturates so a stopped clock stays detected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_q <= 5'h00;
        end else if (trx_rise) begin
            lost_q <= 5'h00;
        end else if (!clk_lost) begin
            lost_q <= lost_q + 5'h01;
        end
    end

    // radio state machine driven by trigger edges and commands
    always_comb begin
        st_d = st_q;
        case (st_q)
            st_off: if (trig_rise) st_d = st_sleep;
            st_sleep: if (trig_fall) st_d = st_off;
            st_pll_on: if (trig_rise) st_d = st_busy_tx;
            st_busy_tx: if (tx_done) st_d = st_pll_on;
            st_aret_on: if (trig_rise) st_d = st_busy_aret;
            st_busy_aret: if (tx_done) st_d = st_aret_on;
            st_rx_on: if (trig_rise) st_d = st_rx_hold;
            st_aack_on: if (trig_rise) st_d = st_rx_hold;
            st_rx_hold: if (trig_fall) st_d = prev_q;
            default: st_d = st_off;
        endcase
        if (cmd_we) begin
            st_d = cmd_state(pwdata[7:0], st_q);
        end
        if (trx_rst) begin
            st_d = st_off;
        end
    end

    // state, trigger and pulse outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= st_off;
            prev_q <= st_off;
            trig_q <= 1'b0;
            tx_start_q <= 1'b0;
            radio_reset_q <= 1'b0;
            trx_clk_en_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_d == st_rx_hold && st_q != st_rx_hold) begin
                prev_q <= st_q;
            end
            trig_q <= trig_d;
            tx_start_q <= trig_rise & ~trx_rst &
                (st_q == st_pll_on || st_q == st_aret_on);
            radio_reset_q <= trx_rst;
            trx_clk_en_q <= ~power_reduction_ctrl & (st_d != st_sleep);
        end
    end

    // radio registers and received length; soft reset clears them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N_REGS; i++) begin
                regs_q[i] <= `RHI_REG_RST;
            end
            rxlen_q <= `RHI_REG_RST;
            wr_ptr_q <= '0;
        end else if (trx_rst) begin
            for (int i = 0; i < N_REGS; i++) begin
                regs_q[i] <= `RHI_REG_RST;
            end
            rxlen_q <= `RHI_REG_RST;
            wr_ptr_q <= '0;
        end else begin
            if (reg_we && (cmd_we || reg_idx >= `RHI_IDX_FREE)) begin
                regs_q[reg_idx] <= pwdata[7:0];
            end
            if (rx_ok && rx_len_valid) begin
                rxlen_q <= rx_len;
                wr_ptr_q <= '0;
            end else if (rx_ok && rx_byte_valid) begin
                wr_ptr_q <= wr_ptr_q + FB_AW'(1);
            end
        end
    end

    // buffer storage; reception wins a same-cycle clash
    always_ff @(posedge pclk) begin
        if (fb_we) begin
            fb_mem[fb_idx] <= pwdata[7:0];
        end
        if (rx_we) begin
            fb_mem[wr_ptr_q] <= rx_lqi_valid ? rx_lqi : rx_byte;
        end
    end

    // transmitter read port, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_rd_byte_q <= 8'h00;
        end else begin
            tx_rd_byte_q <= fb_mem[tx_rd_idx];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_rd_byte = tx_rd_byte_q;
    assign tx_start = tx_start_q;
    assign radio_reset = radio_reset_q;
    assign trx_clk_en = trx_clk_en_q;
    assign radio_state = st_q;

    // checks on timing and state behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_enter_sleep;
        st_q == st_off && trig_rise && !trx_rst;
    endsequence

    sequence s_enter_hold;
        (st_q == st_rx_on || st_q == st_aack_on) && trig_rise && !trx_rst;
    endsequence

    a_reg_wait: assert property (setup && a_reg && trx_avail |=>
        !pready_q) else $error("register access did not wait");
    a_reg_bound: assert property (acc_q == acc_wait && trx_rise &&
        cnt_last |=> pready_q) else $error("register access overran");
    a_lost_zero: assert property (done_lost |=>
        pready_q && prdata_q == 32'h0) else $error("read not zero");
    a_fb_single: assert property (setup && a_fb |=>
        pready_q && !pslverr_q) else $error("buffer access waited");
    a_pin_awake: assert property (setup && a_pin |=>
        pready_q && !pslverr_q) else $error("pin register waited");
    // the first load after reset pulls in unwritten bytes, so skip it
    a_fb_stable: assert property ($past(presetn) && !$past(fb_we) &&
        !$past(rx_we) && $stable(tx_rd_idx) |=> $stable(tx_rd_byte_q))
        else $error("buffer changed without a write");
    a_len_kept: assert property (rx_ok && rx_len_valid && !trx_rst |=>
        rxlen_q == $past(rx_len) && wr_ptr_q == '0)
        else $error("length not captured");
    a_lqi_after: assert property (rx_ok && rx_lqi_valid && !fb_we |=>
        fb_mem[$past(wr_ptr_q)] == $past(rx_lqi))
        else $error("link quality byte misplaced");
    a_soft_reset: assert property (trx_rst |=> radio_reset_q &&
        st_q == st_off ##1 !radio_reset_q) else $error("soft reset");
    a_tx_start: assert property (st_q == st_pll_on && trig_rise &&
        !trx_rst |=> tx_start_q && st_q == st_busy_tx)
        else $error("transmit not started");
    a_sleep_entry: assert property (s_enter_sleep |=>
        st_q == st_sleep && !trx_clk_en_q) else $error("sleep not entered");
    a_hold_return: assert property (s_enter_hold ##1
        (trig_q && !trx_rst && !cmd_we)[*2] |-> st_q == st_rx_hold)
        else $error("hold state left early");
endmodule

/* testbench/rhi_radio_model.sv */
// radio-side model: crystal clock, receive strobes, transmit completion
// assumes the host block gates the crystal through trx_clk_en
`timescale 1ns/1ps
module rhi_radio_model (
    input wire logic pclk, // controller clock
    input wire logic run, // crystal enabled by the host
    input wire logic tx_start, // transmit start pulse
    output logic trx_clk, // 16 mhz radio clock
    output logic tx_done, // transmit finished pulse
    output logic rx_len_valid, // length strobe
    output logic rx_byte_valid, // data strobe
    output logic rx_lqi_valid, // link quality strobe
    output logic [7:0] rx_d // value shared by the three strobes
);
    logic [4:0] tx_cnt_q;
    // quiet outputs until the first frame
    initial begin
        trx_clk = 1'b0;
        tx_done = 1'b0;
        tx_cnt_q = 5'h00;
        rx_len_valid = 1'b0;
        rx_byte_valid = 1'b0;
        rx_lqi_valid = 1'b0;
        rx_d = 8'h00;
    end
    // own crystal, unrelated to pclk; stands still when gated off
    always begin
        #31.25;
        trx_clk = run ? ~trx_clk : 1'b0;
    end
    // a frame takes 20 controller cycles on air
    always @(posedge pclk) begin
        tx_done <= (tx_cnt_q == 5'h01);
        if (tx_start === 1'b1)
            tx_cnt_q <= 5'h14;
        else if (tx_cnt_q != 5'h00)
            tx_cnt_q <= tx_cnt_q - 5'h01;
    end
    // length, then data bytes 0x10+i, then link quality
    task automatic send_frame(input int len, input logic [7:0] link_quality_byte);
        @(posedge pclk);
        rx_len_valid <= 1'b1;
        rx_d <= len[7:0];
        @(posedge pclk);
        rx_len_valid <= 1'b0;
        for (int i = 0; i < len; i++) begin
            rx_byte_valid <= 1'b1;
            rx_d <= 8'h10 + i[7:0];
            @(posedge pclk);
        end
        rx_byte_valid <= 1'b0;
        rx_lqi_valid <= 1'b1;
        rx_d <= link_quality_byte;
        @(posedge pclk);
        rx_lqi_valid <= 1'b0;
        rx_d <= ~link_quality_byte; // no stale value once released
    endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the radio host interface over apb
// assumes rhi_radio_model as far side and rhi_map.svh on the path
`timescale 1ns/1ps
`include "rhi_map.svh"
module tb_top;
    import rhi_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic trx_clk, power_reduction_ctrl, rx_lv, rx_bv, rx_qv;
    logic tx_done, tx_start, radio_reset, clk_en, g_err;
    logic [6:0] tx_idx;
    logic [7:0] rx_d, tx_byte, g_rd;
    rhi_state_t state;
    int g_nw, n_mismatch, n_compared, n_tx, n_rst;
    rhi_top i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trx_clk(trx_clk), .power_reduction_ctrl(power_reduction_ctrl),
        .rx_len_valid(rx_lv), .rx_len(rx_d), .rx_byte_valid(rx_bv),
        .rx_byte(rx_d), .rx_lqi_valid(rx_qv), .rx_lqi(rx_d),
        .tx_done(tx_done), .tx_rd_idx(tx_idx), .tx_rd_byte(tx_byte),
        .tx_start(tx_start), .radio_reset(radio_reset),
        .trx_clk_en(clk_en), .radio_state(state)
    );
    rhi_radio_model i_radio (
        .pclk(pclk), .run(clk_en), .tx_start(tx_start),
        .trx_clk(trx_clk), .tx_done(tx_done), .rx_len_valid(rx_lv),
        .rx_byte_valid(rx_bv), .rx_lqi_valid(rx_qv), .rx_d(rx_d)
    );
    // 100 mhz controller clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // one-cycle pulses, so count them on every edge
    always @(posedge pclk) begin
        if (tx_start === 1'b1)
            n_tx++;
        if (radio_reset === 1'b1)
            n_rst++;
    end
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h lim=%h", $time, got, hi);
        end
    endtask
    task automatic chk_st(input rhi_state_t e);
        chk({28'h0, state}, {28'h0, e});
    endtask
    // request held until pready is seen high; only the watchdog ends a wait
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        g_nw = 0;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            g_nw++;
            @(posedge pclk);
        end
        g_rd = prdata[7:0];
        g_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk({24'h0, g_rd}, {24'h0, e});
    endtask
    function automatic logic [11:0] ra(input logic [3:0] i);
        return {6'h0, i, 2'b00};
    endfunction
    function automatic logic [11:0] fb(input logic [6:0] i);
        return `RHI_FB_FIRST + {3'h0, i, 2'b00};
    endfunction
    // state commands settle a few cycles after the bus returns
    task automatic cmd(input logic [7:0] c);
        apb(1'b1, ra(`RHI_IDX_CMD), c);
        repeat (4) @(posedge pclk);
    endtask
    task automatic t_buf();
        for (int i = 0; i < 128; i++) begin
            apb(1'b1, fb(i[6:0]), i[7:0] ^ 8'h3c);
            chk_in(g_nw, 0, 0);
        end
        for (int i = 0; i < 128; i++)
            rd_chk(fb(i[6:0]), i[7:0] ^ 8'h3c);
        rd_chk(`RHI_FB_LAST, 8'h43);
        rd_chk(`RHI_FB_LAST - 12'h004, 8'h42);
        chk_in(g_nw, 0, 0);
    endtask
    task automatic t_err();
        apb(1'b1, `RHI_REG_END, 8'hff);
        chk(g_err, 1'b1);
        rd_chk(`RHI_REG_END, 8'h00);
        chk(g_err, 1'b1);
    endtask
    task automatic t_reg();
        chk(clk_en, 1'b1);
        rd_chk(ra(`RHI_IDX_STATE), 8'h00);
        chk_in(g_nw, 3, 25);
        apb(1'b1, ra(`RHI_IDX_FREE), 8'ha5);
        chk_in(g_nw, 3, 25);
        apb(1'b1, ra(`RHI_IDX_STATE), 8'h5a);
        rd_chk(ra(`RHI_IDX_FREE), 8'ha5);
        rd_chk(ra(`RHI_IDX_STATE), 8'h00);
    endtask
    task automatic t_trig();
        apb(1'b1, fb(7'h00), 8'h03);
        cmd(`RHI_CMD_PLL);
        chk_st(st_pll_on);
        apb(1'b1, `RHI_PIN_ADDR, 8'h02);
        apb(1'b1, `RHI_PIN_ADDR, 8'h00);
        chk_st(st_busy_tx);
        repeat (30) @(posedge pclk);
        chk_st(st_pll_on);
        chk(n_tx, 1);
        cmd(`RHI_CMD_ARET);
        rd_chk(ra(`RHI_IDX_RXLEN), 8'h00);
        apb(1'b1, `RHI_PIN_ADDR, 8'h02);
        rd_chk(`RHI_PIN_ADDR, 8'h02);
        chk_st(st_busy_aret);
        apb(1'b1, `RHI_PIN_ADDR, 8'h00);
        repeat (30) @(posedge pclk);
        chk_st(st_aret_on);
        chk(n_tx, 2);
    endtask
    task automatic t_sleep();
        cmd(`RHI_CMD_OFF);
        apb(1'b1, `RHI_PIN_ADDR, 8'h02);
        repeat (4) @(posedge pclk);
        chk_st(st_sleep);
        chk(clk_en, 1'b0);
        rd_chk(`RHI_PIN_ADDR, 8'h02);
        chk_in(g_nw, 0, 0);
        rd_chk(ra(`RHI_IDX_FREE), 8'h00);
        chk_in(g_nw, 0, 16);
        apb(1'b1, `RHI_PIN_ADDR, 8'h00);
        repeat (40) @(posedge pclk);
        chk_st(st_off);
    endtask
    task automatic t_rx();
        cmd(`RHI_CMD_RX);
        i_radio.send_frame(5, 8'hc8);
        rd_chk(ra(`RHI_IDX_RXLEN), 8'h05);
        for (int i = 0; i < 5; i++)
            rd_chk(fb(i[6:0]), 8'h10 + i[7:0]);
        rd_chk(fb(7'h05), 8'hc8);
        rd_chk(fb(7'h06), 8'h3a);
        tx_idx <= 7'h01;
        repeat (3) @(posedge pclk);
        chk(tx_byte, 8'h11);
        apb(1'b1, `RHI_PIN_ADDR, 8'h02);
        repeat (2) @(posedge pclk);
        chk_st(st_rx_hold);
        apb(1'b1, `RHI_PIN_ADDR, 8'h00);
        repeat (2) @(posedge pclk);
        chk_st(st_rx_on);
        cmd(`RHI_CMD_AACK);
        chk_st(st_aack_on);
        apb(1'b1, `RHI_PIN_ADDR, 8'h02);
        repeat (2) @(posedge pclk);
        chk_st(st_rx_hold);
        apb(1'b1, `RHI_PIN_ADDR, 8'h00);
        repeat (2) @(posedge pclk);
        chk_st(st_aack_on);
    endtask
    task automatic t_rst();
        apb(1'b1, ra(`RHI_IDX_FREE), 8'h3c);
        apb(1'b1, `RHI_PIN_ADDR, 8'h01);
        repeat (2) @(posedge pclk);
        chk(n_rst, 1);
        chk_st(st_off);
        rd_chk(`RHI_PIN_ADDR, 8'h00);
        repeat (40) @(posedge pclk);
        rd_chk(ra(`RHI_IDX_FREE), 8'h00);
        rd_chk(fb(7'h00), 8'h10);
    endtask
    task automatic t_pwr();
        apb(1'b1, ra(`RHI_IDX_FREE), 8'h77);
        power_reduction_ctrl <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(clk_en, 1'b0);
        rd_chk(ra(`RHI_IDX_STATE), 8'h00);
        chk_in(g_nw, 0, 16);
        rd_chk(ra(`RHI_IDX_FREE), 8'h00);
        power_reduction_ctrl <= 1'b0;
        // let the crystal restart before touching registers again
        repeat (20) @(posedge pclk);
        rd_chk(ra(`RHI_IDX_FREE), 8'h77);
    endtask
    // cut a hang short well beyond the expected run time
    initial begin
        #500000;
        n_mismatch++;
        close_out();
    end
    // reset, then the scenarios in order
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        power_reduction_ctrl = 1'b0;
        tx_idx = 7'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40) @(posedge pclk);
        t_buf();
        t_err();
        t_reg();
        t_trig();
        t_sleep();
        t_rx();
        t_rst();
        t_pwr();
        close_out();
    end
endmodule
